// ### src/zai_defines.vh
/*
 * constants for the zone aux line interlock block: apb offsets, field
 * positions, line function codes, reset values and timing counts.
 * assumes inclusion by bare name from the design files.
 */
`ifndef ZAI_DEFINES_VH
`define ZAI_DEFINES_VH

// ****************************************************************
// register byte offsets
// ****************************************************************
`define ZAI_OFS_CTRL     8'h00
`define ZAI_OFS_LINE0    8'h04
`define ZAI_OFS_LINE1    8'h08
`define ZAI_OFS_BLOCK    8'h0c
`define ZAI_OFS_CLEAR    8'h10
`define ZAI_OFS_STATUS   8'h14

// ****************************************************************
// field positions
// ****************************************************************
`define ZAI_CTRL_FIRST   0
`define ZAI_CTRL_LAST    1
`define ZAI_LN_FUNC_LO   0
`define ZAI_LN_FUNC_HI   2
`define ZAI_LN_ZONE      3
`define ZAI_LN_INV       4
`define ZAI_LN_EXT_OUT   5
`define ZAI_LN_EXT_OE    6

// ****************************************************************
// line function codes
// ****************************************************************
`define ZAI_FN_EXT       3'h0
`define ZAI_FN_RUNREQ    3'h1
`define ZAI_FN_ACCUM     3'h2
`define ZAI_FN_LANEFULL  3'h3
`define ZAI_FN_OCCUPIED  3'h4

// ****************************************************************
// reset values
// ****************************************************************
`define ZAI_RST_CTRL     2'h3
`define ZAI_RST_LINE     7'h00
`define ZAI_RST_BLOCK_MS 16'h1388
`define ZAI_RST_CLEAR_MS 16'h1770

// ****************************************************************
// timing
// ****************************************************************
`define ZAI_CLK_NS       20
`define ZAI_TICK_NS      1000000
`define ZAI_TICK_CYC     (`ZAI_TICK_NS / `ZAI_CLK_NS)

`endif

// ### src/zai_lane_filter.v
/*
 * block/clear filter for the lane-full input: the filtered state follows
 * the raw level only after it has held steady for the configured time.
 * assumes a one-cycle tick per millisecond and a raw level on mclk.
 */
`default_nettype none

module zai_lane_filter #(
    parameter W = 16
) (
    // clock and reset
    input  wire         mclk,
    input  wire         rst_n,
    // timing
    input  wire         tick,
    input  wire [W-1:0] block_ms,
    input  wire [W-1:0] clear_ms,
    // level in, filtered level out
    input  wire         raw,
    output reg          full_reg
);

    reg  [W-1:0] cnt_reg;
    wire [W-1:0] limit;

    assign limit = raw ? block_ms : clear_ms;

    // ****************************************************************
    // hold timer
    // ****************************************************************
    always @(posedge mclk) begin
        if (!rst_n) begin
            cnt_reg  <= {W{1'b0}};
            full_reg <= 1'b0;
        end else if (raw == full_reg) begin
            // level went back before expiry: restart, keep state
            cnt_reg <= {W{1'b0}};
        end else if (cnt_reg >= limit) begin
            full_reg <= raw;
            cnt_reg  <= {W{1'b0}};
        end else if (tick) begin
            cnt_reg <= cnt_reg + {{(W-1){1'b0}}, 1'b1};
        end
    end

endmodule // zai_lane_filter

`default_nettype wire

// ### src/zai_zone_interlock.v
/*
 * two-zone aux line interlock: two configurable aux lines drive run
 * request, accumulate or an occupied output for the upstream or downstream
 * zone, or filtered lane-full for the downstream zone; apb slave for configuration and status.
 * assumes sensor and aux pins are asynchronous, neighbour flags come
 * from logic on mclk.
 */
// Implementation choices: the address map and the APB interface to the registers.
`default_nettype none
`include "zai_defines.vh"

// Overview of operation
// - no run request, first zone never takes in
// - active run request runs upstream zone intake when first zone
// - intermediate zone conveys when next zone clear
// - active accumulate holds arriving item in zone
// - lane full accumulates after full block time
// - lane full releases after full clear time
// - any line set to lane full disables arrival fault detection, even while lane full is inactive
// - lane clear releases last zone items immediately
// - block and clear times independently configurable
// - upstream handshake: run request plus occupied
// - downstream handshake: accumulate in, occupied out
// - occupied output follows its selected zone
// - invert makes input active when off
// - inverted occupied output drives off when occupied
// - last zone discharges unless accumulate active
// - external control line leaves zones untouched
module zai_zone_interlock #(
    parameter TICK_CYC = `ZAI_TICK_CYC,
    parameter TW       = 16
) (
    // clock and reset
    input  wire         mclk,
    input  wire         rst_n,
    // apb slave
    input  wire         psel,
    input  wire         penable,
    input  wire         pwrite,
    input  wire [7:0]   paddr,
    input  wire [31:0]  pwdata,
    output reg  [31:0]  prdata,
    output reg          pready,
    output reg          pslverr,
    // aux lines, index 0 left, 1 right
    input  wire [1:0]   aux_in,
    output reg  [1:0]   aux_out,
    output reg  [1:0]   aux_oe,
    // zone sensors, index 0 upstream, 1 downstream, high when blocked
    input  wire [1:0]   zone_sensor,
    // neighbour flags from zone messaging
    input  wire         upstream_feed,
    input  wire         next_clear,
    // zone motors and fault detection enable
    output reg  [1:0]   motor_run,
    output reg          arrival_fault_en
);

    // ****************************************************************
    // helper functions
    // ****************************************************************
    function line_func_is;
        input [6:0] cfg;
        input [2:0] fn;
        begin
            line_func_is = (cfg[`ZAI_LN_FUNC_HI:`ZAI_LN_FUNC_LO] == fn);
        end
    endfunction

    // line drives a given function towards a given zone
    function line_hits;
        input [6:0] cfg;
        input [2:0] fn;
        input       zone;
        begin
            line_hits = line_func_is(cfg, fn) && (cfg[`ZAI_LN_ZONE] == zone);
        end
    endfunction

    // ****************************************************************
    // state
    // ****************************************************************
    reg  [1:0]    ctrl_reg;
    reg  [6:0]    line0_reg;
    reg  [6:0]    line1_reg;
    reg  [TW-1:0] block_reg;
    reg  [TW-1:0] clear_reg;
    reg  [1:0]    aux_s1_reg;
    reg  [1:0]    aux_s2_reg;
    reg  [1:0]    sen_s1_reg;
    reg  [1:0]    sen_s2_reg;
    reg  [31:0]   pre_reg;
    reg           tick_reg;

    wire          lane_full;
    wire [1:0]    act;
    wire [1:0]    occ;
    wire [1:0]    run_req;
    wire [1:0]    accum;
    wire          lf_sel;
    wire          lf_raw;
    wire          is_first;
    wire          is_last;
    reg  [1:0]    motor_next;
    reg  [1:0]    aux_out_next;
    reg  [1:0]    aux_oe_next;
    reg  [31:0]   rd_next;
    reg           err_next;
    wire          setup;
    wire          wr_en;

    // ****************************************************************
    // pin synchronisers
    // ****************************************************************
    always @(posedge mclk) begin
        if (!rst_n) begin
            aux_s1_reg <= 2'h0;
            aux_s2_reg <= 2'h0;
            sen_s1_reg <= 2'h0;
            sen_s2_reg <= 2'h0;
        end else begin
            aux_s1_reg <= aux_in;
            aux_s2_reg <= aux_s1_reg;
            sen_s1_reg <= zone_sensor;
            sen_s2_reg <= sen_s1_reg;
        end
    end

    // ****************************************************************
    // millisecond tick
    // ****************************************************************
    always @(posedge mclk) begin
        if (!rst_n) begin
            pre_reg  <= 32'h0;
            tick_reg <= 1'b0;
        end else if (pre_reg >= TICK_CYC - 1) begin
            pre_reg  <= 32'h0;
            tick_reg <= 1'b1;
        end else begin
            pre_reg  <= pre_reg + 32'h1;
            tick_reg <= 1'b0;
        end
    end

    // ****************************************************************
    // line decode
    // ****************************************************************
    // electrical level reads as active when off if inverted
    assign act[0] = aux_s2_reg[0] ^ line0_reg[`ZAI_LN_INV];
    assign act[1] = aux_s2_reg[1] ^ line1_reg[`ZAI_LN_INV];
    assign occ      = sen_s2_reg;
    assign is_first = ctrl_reg[`ZAI_CTRL_FIRST];
    assign is_last  = ctrl_reg[`ZAI_CTRL_LAST];

    // external-control lines match no function, so they never reach here
    assign run_req[0] = (act[0] && line_hits(line0_reg, `ZAI_FN_RUNREQ, 1'b0))
                      || (act[1] && line_hits(line1_reg, `ZAI_FN_RUNREQ, 1'b0));
    assign run_req[1] = (act[0] && line_hits(line0_reg, `ZAI_FN_RUNREQ, 1'b1))
                      || (act[1] && line_hits(line1_reg, `ZAI_FN_RUNREQ, 1'b1));

    // lane full always acts on the downstream zone
    assign lf_sel = line_func_is(line0_reg, `ZAI_FN_LANEFULL)
                  || line_func_is(line1_reg, `ZAI_FN_LANEFULL);
    assign lf_raw = (act[0] && line_func_is(line0_reg, `ZAI_FN_LANEFULL))
                  || (act[1] && line_func_is(line1_reg, `ZAI_FN_LANEFULL));

    zai_lane_filter #(
        .W        (TW)
    ) u_lane (
        .mclk     (mclk),
        .rst_n    (rst_n),
        .tick     (tick_reg),
        .block_ms (block_reg),
        .clear_ms (clear_reg),
        .raw      (lf_raw),
        .full_reg (lane_full)
    );

    assign accum[0] = (act[0] && line_hits(line0_reg, `ZAI_FN_ACCUM, 1'b0))
                    || (act[1] && line_hits(line1_reg, `ZAI_FN_ACCUM, 1'b0));
    assign accum[1] = (act[0] && line_hits(line0_reg, `ZAI_FN_ACCUM, 1'b1))
                    || (act[1] && line_hits(line1_reg, `ZAI_FN_ACCUM, 1'b1))
                    || (lf_sel && lane_full);

    // ****************************************************************
    // zone motor control
    // ****************************************************************
    always @* begin
        motor_next = 2'h0;
        // upstream zone intake: first zone needs a run request
        if (is_first) begin
            if (run_req[0] && !occ[0])
                motor_next[0] = 1'b1;
        end else if (upstream_feed && !occ[0]) begin
            motor_next[0] = 1'b1;
        end
        // upstream zone discharge into downstream zone
        if (occ[0] && !accum[0] && !occ[1])
            motor_next[0] = 1'b1;
        // downstream zone intake follows its feeder
        if (!occ[1] && (motor_next[0] || run_req[1]))
            motor_next[1] = 1'b1;
        // downstream zone discharge
        if (occ[1] && !accum[1]) begin
            if (is_last || lf_sel)
                motor_next[1] = 1'b1;
            else if (next_clear)
                motor_next[1] = 1'b1;
        end
        // accumulate stops the arriving item at its sensor
        if (occ[1] && accum[1])
            motor_next[1] = 1'b0;
    end

    // ****************************************************************
    // aux outputs
    // ****************************************************************
    always @* begin
        aux_out_next = 2'h0;
        aux_oe_next  = 2'h0;
        if (line_func_is(line0_reg, `ZAI_FN_OCCUPIED)) begin
            // inverted occupied output drives off while occupied
            aux_out_next[0] = occ[line0_reg[`ZAI_LN_ZONE]]
                            ^ line0_reg[`ZAI_LN_INV];
            aux_oe_next[0]  = 1'b1;
        end else if (line_func_is(line0_reg, `ZAI_FN_EXT)) begin
            aux_out_next[0] = line0_reg[`ZAI_LN_EXT_OUT];
            aux_oe_next[0]  = line0_reg[`ZAI_LN_EXT_OE];
        end
        if (line_func_is(line1_reg, `ZAI_FN_OCCUPIED)) begin
            aux_out_next[1] = occ[line1_reg[`ZAI_LN_ZONE]]
                            ^ line1_reg[`ZAI_LN_INV];
            aux_oe_next[1]  = 1'b1;
        end else if (line_func_is(line1_reg, `ZAI_FN_EXT)) begin
            aux_out_next[1] = line1_reg[`ZAI_LN_EXT_OUT];
            aux_oe_next[1]  = line1_reg[`ZAI_LN_EXT_OE];
        end
    end

    always @(posedge mclk) begin
        if (!rst_n) begin
            motor_run        <= 2'h0;
            aux_out          <= 2'h0;
            aux_oe           <= 2'h0;
            arrival_fault_en <= 1'b1;
        end else begin
            motor_run        <= motor_next;
            aux_out          <= aux_out_next;
            aux_oe           <= aux_oe_next;
            arrival_fault_en <= !lf_sel;
        end
    end

    // ****************************************************************
    // apb slave
    // ****************************************************************
    // read data is captured in the setup cycle, so the access phase
    // completes on its first edge with no wait state
    assign setup = psel && !penable;
    assign wr_en = psel && penable && pready && pwrite && !pslverr;

    always @* begin
        rd_next  = 32'h0;
        err_next = 1'b0;
        case (paddr)
            `ZAI_OFS_CTRL:   rd_next[1:0]    = ctrl_reg;
            `ZAI_OFS_LINE0:  rd_next[6:0]    = line0_reg;
            `ZAI_OFS_LINE1:  rd_next[6:0]    = line1_reg;
            `ZAI_OFS_BLOCK:  rd_next[TW-1:0] = block_reg;
            `ZAI_OFS_CLEAR:  rd_next[TW-1:0] = clear_reg;
            `ZAI_OFS_STATUS: rd_next[7:0]    = {arrival_fault_en, lane_full,
                                                motor_run, occ, aux_s2_reg};
            default:         err_next        = 1'b1;
        endcase
        if (pwrite)
            rd_next = 32'h0;
        if (pwrite && (paddr == `ZAI_OFS_STATUS))
            err_next = 1'b1;
    end

    always @(posedge mclk) begin
        if (!rst_n) begin
            prdata  <= 32'h0;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else if (setup) begin
            prdata  <= rd_next;
            pready  <= 1'b1;
            pslverr <= err_next;
        end else begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    always @(posedge mclk) begin
        if (!rst_n) begin
            ctrl_reg  <= `ZAI_RST_CTRL;
            line0_reg <= `ZAI_RST_LINE;
            line1_reg <= `ZAI_RST_LINE;
            block_reg <= `ZAI_RST_BLOCK_MS;
            clear_reg <= `ZAI_RST_CLEAR_MS;
        end else if (wr_en) begin
            case (paddr)
                `ZAI_OFS_CTRL:  ctrl_reg  <= pwdata[1:0];
                `ZAI_OFS_LINE0: line0_reg <= pwdata[6:0];
                `ZAI_OFS_LINE1: line1_reg <= pwdata[6:0];
                `ZAI_OFS_BLOCK: block_reg <= pwdata[TW-1:0];
                `ZAI_OFS_CLEAR: clear_reg <= pwdata[TW-1:0];
                default:        ctrl_reg  <= ctrl_reg;
            endcase
        end
    end

endmodule // zai_zone_interlock

`default_nettype wire

// ### testbench/zai_plc_model.sv
/*
 * model of the outside equipment on the two aux lines: a feeder that raises
 * run request on line 0, or an acceptor that drives accumulate on line 1.
 * assumes the bench resolves the wire levels and hands them back on line.
 */
`default_nettype none

module zai_plc_model (
    // clock and reset
    input  wire logic       mclk,
    input  wire logic       rst_n,
    // what the bench wants of the equipment
    input  wire logic       feed_want,
    input  wire logic       hold_want,
    input  wire logic       down,
    input  wire logic       inv,
    // aux wires
    input  wire logic [1:0] line,
    output logic      [1:0] drv,
    output logic      [1:0] drv_en
);
    timeunit 1ns;
    timeprecision 1ps;

    always @(posedge mclk) begin
        if (!rst_n) begin
            drv    <= 2'h0;
            drv_en <= 2'h0;
        end else if (!down) begin
            // feeder only asks while the zone does not show occupied
            drv_en <= 2'h1;
            drv[0] <= (feed_want && !(line[1] ^ inv)) ^ inv;
            drv[1] <= 1'b0;
        end else begin
            drv_en <= 2'h2;
            drv[1] <= hold_want ^ inv;
            drv[0] <= 1'b0;
        end
    end
endmodule // zai_plc_model

`default_nettype wire

// ### testbench/zai_monitor.sv
/*
 * concurrent checks on the zone interlock ports, bound into the design.
 * assumes configuration is only changed through apb writes seen here.
 */
`default_nettype none

module zai_monitor #(
    parameter TICK_CYC = 4
) (
    // clock and reset
    input  wire logic        mclk,
    input  wire logic        rst_n,
    // apb
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic        pready,
    input  wire logic        pslverr,
    // pins
    input  wire logic [1:0]  aux_in,
    input  wire logic [1:0]  aux_out,
    input  wire logic [1:0]  aux_oe,
    input  wire logic [1:0]  zone_sensor,
    input  wire logic [1:0]  motor_run,
    input  wire logic        arrival_fault_en
);
    timeunit 1ns;
    timeprecision 1ps;

    // ****************************************************************
    // shadow of configuration and a settle counter
    // ****************************************************************
    logic [6:0] l0_reg;
    logic [6:0] l1_reg;
    logic [1:0] ctrl_reg;
    logic [3:0] stab_reg;
    logic [1:0] sens_q;
    logic [1:0] aux_q;
    wire        wr_c = psel & penable & pready & pwrite;
    // pins unchanged at this very edge too: stab only drops one edge after a pin moves
    wire        calm = stab_reg >= 4'h4 && zone_sensor == sens_q && aux_in == aux_q;

    // stab counts edges since the last pin change or write: the pin path is 3 edges deep
    always @(posedge mclk) begin
        if (!rst_n) begin
            l0_reg   <= 7'h00;
            l1_reg   <= 7'h00;
            ctrl_reg <= 2'h3;
            stab_reg <= 4'h0;
            sens_q   <= 2'h0;
            aux_q    <= 2'h0;
        end else begin
            if (wr_c && paddr == 8'h00) ctrl_reg <= pwdata[1:0];
            if (wr_c && paddr == 8'h04) l0_reg <= pwdata[6:0];
            if (wr_c && paddr == 8'h08) l1_reg <= pwdata[6:0];
            sens_q <= zone_sensor;
            aux_q  <= aux_in;
            if (wr_c || zone_sensor != sens_q || aux_in != aux_q) stab_reg <= 4'h0;
            else if (stab_reg != 4'hf) stab_reg <= stab_reg + 4'h1;
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    apb_answer_a: assert property (psel && !penable |=> pready && penable)
        else $error("apb access not answered in first access cycle");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    bad_access_a: assert property (psel && penable && pready
        && (paddr > 8'h14 || (pwrite && paddr == 8'h14)) |-> pslverr)
        else $error("bad access without error response");
    no_intake_a: assert property (calm && ctrl_reg[0] && l0_reg[2:0] != 3'h1
        && l1_reg[2:0] != 3'h1 && !zone_sensor[0] |-> !motor_run[0])
        else $error("first zone takes in without run request");
    run_request_a: assert property (calm && ctrl_reg[0] && l0_reg[4:0] == 5'h01
        && aux_in[0] && !zone_sensor[0] |-> motor_run[0])
        else $error("run request does not run first zone");
    occ_out_a: assert property (calm && l1_reg[2:0] == 3'h4
        |-> aux_oe[1] && aux_out[1] == (zone_sensor[l1_reg[3]] ^ l1_reg[4]))
        else $error("occupied output wrong");
    accum_stop_a: assert property (calm && l1_reg[3:0] == 4'ha
        && (aux_in[1] ^ l1_reg[4]) && zone_sensor[1] |-> !motor_run[1])
        else $error("accumulated zone keeps running");
    fault_gate_a: assert property (stab_reg >= 4 |-> arrival_fault_en
        == !(l0_reg[2:0] == 3'h3 || l1_reg[2:0] == 3'h3))
        else $error("arrival fault enable wrong for lane full");
    ext_line_a: assert property (stab_reg >= 4 && l0_reg[2:0] == 3'h0
        |-> aux_oe[0] == l0_reg[6] && (!l0_reg[6] || aux_out[0] == l0_reg[5]))
        else $error("external control line drive wrong");
    reset_out_a: assert property (disable iff (1'b0) !rst_n
        |=> motor_run == 2'h0 && aux_oe == 2'h0 && !pready && arrival_fault_en)
        else $error("outputs not at reset level");
endmodule // zai_monitor

bind zai_zone_interlock zai_monitor #(.TICK_CYC(TICK_CYC)) u_mon (
    .mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
    .aux_in(aux_in), .aux_out(aux_out), .aux_oe(aux_oe), .zone_sensor(zone_sensor),
    .motor_run(motor_run), .arrival_fault_en(arrival_fault_en));

`default_nettype wire

// ### testbench/tb.sv
/*
 * self-checking bench for the zone interlock: apb tasks and pin scenarios.
 * assumes the aux wires have a pull-down and the tick is shortened to 4 cycles.
 */
`default_nettype none

module tb;
    timeunit 1ns;
    timeprecision 1ps;

    logic mclk, rst_n, psel, penable, pwrite, pready, pslverr, next_clear, afe;
    logic feed_want, hold_want, down, inv;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, r;
    logic [1:0]  aux_out, aux_oe, zone_sensor, motor_run, drv, drv_en, aux_w;
    logic        e;
    int          bad_count, n_tests;
    logic [7:0]  ofs [5] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10};
    logic [31:0] rv  [5] = '{32'h3, 32'h0, 32'h0, 32'h1388, 32'h1770};

    // released lines fall to the pull-down level
    for (genvar i = 0; i < 2; i++) begin : g_wire
        assign aux_w[i] = aux_oe[i] ? aux_out[i] : (drv_en[i] ? drv[i] : 1'b0);
    end

    zai_zone_interlock #(.TICK_CYC(4), .TW(16)) dut (
        .mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .aux_in(aux_w), .aux_out(aux_out), .aux_oe(aux_oe),
        .zone_sensor(zone_sensor), .upstream_feed(1'b0), .next_clear(next_clear),
        .motor_run(motor_run), .arrival_fault_en(afe));

    zai_plc_model u_plc (
        .mclk(mclk), .rst_n(rst_n), .feed_want(feed_want), .hold_want(hold_want),
        .down(down), .inv(inv), .line(aux_w), .drv(drv), .drv_en(drv_en));

    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // one apb transfer; values read right after the edge are those sampled at it
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge mclk);
        psel <= 1'b1; penable <= 1'b0; paddr <= a; pwrite <= w; pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do begin
            @(posedge mclk);
            n++;
        end while (!pready && n < 50);
        if (n >= 50) bad_count++;
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wt(input int n);
        repeat (n) @(posedge mclk);
    endtask

    initial begin
        repeat (5000) @(posedge mclk);
        bad_count++;
        tally_and_finish();
    end

    initial begin
        bad_count = 0; n_tests = 0; rst_n = 1'b0; psel = 1'b0; penable = 1'b0;
        pwrite = 1'b0; paddr = 8'h00; pwdata = 32'h0; zone_sensor = 2'h0;
        next_clear = 1'b1; feed_want = 1'b0; hold_want = 1'b0; down = 1'b0; inv = 1'b0;
        wt(4);
        rst_n <= 1'b1;
        for (int i = 0; i < 5; i++) begin
            apb(ofs[i], 1'b0, 32'h0);
            chk("reset value", r, rv[i]);
        end
        apb(8'h18, 1'b0, 32'h0);
        chk("unmapped error", e, 1);
        apb(8'h14, 1'b1, 32'hff);
        chk("status write error", e, 1);
        apb(8'h0c, 1'b1, 32'h5);
        apb(8'h10, 1'b1, 32'h6);
        apb(8'h10, 1'b0, 32'h0);
        chk("clear time", r, 32'h6);
        // external line driven high must not wake the first zone
        apb(8'h04, 1'b1, 32'h60);
        wt(6);
        chk("idle intake", motor_run[0], 0);
        chk("ext drive", {aux_oe[0], aux_out[0]}, 2'h3);
        // ****************************************************************
        // upstream handshake, plain and inverted
        // ****************************************************************
        apb(8'h04, 1'b1, 32'h01);
        apb(8'h08, 1'b1, 32'h04);
        feed_want <= 1'b1;
        wt(8);
        chk("intake on request", motor_run[0], 1);
        chk("occupied clear", aux_out[1], 0);
        zone_sensor <= 2'h1;
        wt(8);
        chk("occupied set", aux_out[1], 1);
        chk("feeder holds off", aux_w[0], 0);
        apb(8'h04, 1'b1, 32'h11);
        apb(8'h08, 1'b1, 32'h14);
        inv <= 1'b1;
        wt(8);
        chk("inverted occupied", aux_out[1], 0);
        zone_sensor <= 2'h0;
        wt(8);
        chk("inverted clear", aux_out[1], 1);
        chk("inverted request", motor_run[0], 1);
        feed_want <= 1'b0; inv <= 1'b0;
        // ****************************************************************
        // downstream handshake and intermediate release
        // ****************************************************************
        apb(8'h04, 1'b1, 32'h0c);
        apb(8'h08, 1'b1, 32'h0a);
        down <= 1'b1; hold_want <= 1'b1; zone_sensor <= 2'h2;
        wt(8);
        chk("last zone held", motor_run[1], 0);
        chk("ready to discharge", aux_out[0], 1);
        hold_want <= 1'b0;
        wt(8);
        chk("last zone discharges", motor_run[1], 1);
        apb(8'h08, 1'b1, 32'h00);
        apb(8'h00, 1'b1, 32'h0);
        next_clear <= 1'b0;
        wt(8);
        chk("wait for next zone", motor_run[1], 0);
        next_clear <= 1'b1;
        wt(8);
        chk("convey to next zone", motor_run[1], 1);
        // accumulate on the intermediate upstream zone
        apb(8'h08, 1'b1, 32'h02);
        hold_want <= 1'b1; zone_sensor <= 2'h1;
        wt(8);
        chk("intermediate held", motor_run[0], 0);
        hold_want <= 1'b0;
        wt(8);
        chk("intermediate conveys", motor_run[0], 1);
        zone_sensor <= 2'h2;
        // ****************************************************************
        // lane full filter: block 5, clear 6 ticks of 4 cycles
        // ****************************************************************
        apb(8'h08, 1'b1, 32'h0b);
        next_clear <= 1'b0;
        wt(6);
        chk("fault detect off", afe, 0);
        chk("release without confirm", motor_run[1], 1);
        hold_want <= 1'b1;
        wt(16);
        hold_want <= 1'b0;
        wt(2);
        hold_want <= 1'b1;
        wt(12);
        chk("block restarted", motor_run[1], 1);
        wt(24);
        chk("blocked", motor_run[1], 0);
        apb(8'h14, 1'b0, 32'h0);
        chk("status lane full", r[6], 1);
        hold_want <= 1'b0;
        wt(14);
        chk("clear pending", motor_run[1], 0);
        wt(26);
        chk("cleared", motor_run[1], 1);
        tally_and_finish();
    end
endmodule // tb

`default_nettype wire
